// ==== core/tpn_pkg.sv ====
// Purpose: constants shared by the pulse and no-response timer block
// Assumes: 100 MHz clock, 8-bit register port
// Notes: times kept in their printed unit, cycle counts derived here
package tpn_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PROTO = 8'h01;
  localparam logic [7:0] ADDR_PULSE = 8'h06;
  localparam logic [7:0] ADDR_NORESP = 8'h07;
  localparam logic [7:0] ADDR_RXWAIT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0D;
  // ---------------------------------------------------------------
  // reset values and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PROTO = 8'h00;
  localparam logic [7:0] RST_PULSE = 8'h00;
  localparam logic [7:0] RST_NORESP = 8'h0E;
  localparam logic [7:0] RST_RXWAIT = 8'h1F;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam int PROTO_LSB = 0;
  localparam int RATE_LSB = 2;
  localparam int IRQ_NORESP_BIT = 0;
  localparam int IRQ_PULSE_BIT = 1;
  localparam int IRQ_W = 2;
  typedef enum logic [1:0] {
    TPN_VIC_LOW = 2'b00,
    TPN_VIC_HIGH = 2'b01,
    TPN_PROX_A = 2'b10,
    TPN_PROX_OTHER = 2'b11
  } tpn_proto_e;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_PS = 10000;
  localparam longint PULSE_STEP_PS = 73700;
  localparam longint NORESP_STEP_PS = 37760000;
  localparam longint RXWAIT_STEP_PS = 9440000;
  localparam longint PL_VIC_NS = 9440;
  localparam longint PL_A106_NS = 2360;
  localparam longint PL_A212_NS = 1400;
  localparam longint PL_A424_NS = 737;
  localparam longint PL_A848_NS = 442;
  localparam logic [9:0] PL_VIC_CYC =
    10'((PL_VIC_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [9:0] PL_A106_CYC =
    10'((PL_A106_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [9:0] PL_A212_CYC =
    10'((PL_A212_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [9:0] PL_A424_CYC =
    10'((PL_A424_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [9:0] PL_A848_CYC =
    10'((PL_A848_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam longint NR_VIC_LOW_US = 1812;
  localparam longint NR_VIC_HIGH_US = 755;
  localparam longint NR_OTHER_US = 529;
  localparam longint RXW_VIC_US = 293;
  localparam longint RXW_OTHER_US = 66;
  localparam logic [7:0] NR_VIC_LOW =
    8'((NR_VIC_LOW_US * 1000000 + NORESP_STEP_PS / 2) / NORESP_STEP_PS);
  localparam logic [7:0] NR_VIC_HIGH =
    8'((NR_VIC_HIGH_US * 1000000 + NORESP_STEP_PS / 2) / NORESP_STEP_PS);
  localparam logic [7:0] NR_OTHER =
    8'((NR_OTHER_US * 1000000 + NORESP_STEP_PS / 2) / NORESP_STEP_PS);
  localparam logic [7:0] RXW_VIC =
    8'((RXW_VIC_US * 1000000 + RXWAIT_STEP_PS / 2) / RXWAIT_STEP_PS);
  localparam logic [7:0] RXW_OTHER =
    8'((RXW_OTHER_US * 1000000 + RXWAIT_STEP_PS / 2) / RXWAIT_STEP_PS);
endpackage : tpn_pkg

// ==== core/tpn_sync3.sv ====
// Purpose: three-stage synchroniser for a pin level
// Assumes: pin is asynchronous to clk
// Notes: level moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module tpn_sync3 (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule : tpn_sync3
`default_nettype wire

// ==== core/tpn_step_tick.sv ====
// Purpose: one-cycle enable every STEP_PS on average
// Assumes: STEP_PS not below CLK_PS
// Notes: fractional accumulator, so non-integer steps keep no drift
`timescale 1ns/1ps
`default_nettype none
module tpn_step_tick #(
  parameter longint STEP_PS = 73700,
  parameter longint CLK_PS = 10000
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clear,
  output logic tick
);
  localparam logic [31:0] STEP = 32'(STEP_PS);
  localparam logic [31:0] INC = 32'(CLK_PS);
  logic [31:0] acc;
  logic [31:0] next_acc;
  logic [31:0] sum;

  if (STEP_PS < CLK_PS || STEP_PS >= 64'h7FFFFFFF) begin : g_chk
    $error("step must lie between one clock and 2^31 ps");
  end

  always_comb begin
    sum = acc + INC;
    tick = 1'b0;
    next_acc = sum;
    if (clear) begin
      next_acc = 32'h0;
    end else if (sum >= STEP) begin
      tick = 1'b1;
      next_acc = sum - STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= 32'h0;
    end else begin
      acc <= next_acc;
    end
  end
endmodule : tpn_step_tick
`default_nettype wire

// ==== core/tpn_timer.sv ====
// Purpose: transmit pulse length and receive no-response timing
// Assumes: framing strobes come from logic on clk; en_pin is a pin
// Notes: register port answers reads one cycle after the strobe
//
// How it works
// R1: override zero means pulse length comes from the selected protocol
// R2: nonzero override N gives a pulse of N steps of 73.7 ns
// R3: override clears at reset, while enable low, on protocol write
// R4: protocol pulses 9.44us vicinity; 2.36us,1.4us,737ns,442ns type A
// R5: no-response timer starts at end of transmitted end-of-frame
// R6: expiry without response raises interrupt and sets no-response flag
// R7: no-response value M means M steps of 37.76 us
// R8: no-response register loads 0x0E at reset and while enable low
// R9: protocol write presets 1812us, 755us vicinity, 529us otherwise
// R10: no-response interrupt only while vicinity protocol selected
// R11: receive decoders held after end-of-frame, steps of 9.44 us
// R12: response start before expiry stops timer with no interrupt
`timescale 1ns/1ps
`default_nettype none
module tpn_timer (
  input wire logic clk,
  input wire logic reset,
  input wire logic en_pin,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic tx_start,
  output logic tx_pulse,
  input wire logic tx_eof_end,
  input wire logic tag_resp_start,
  output logic rx_dec_hold,
  output logic noresp_busy,
  output logic irq
);
  typedef enum logic {
    TPN_IDLE = 1'b0,
    TPN_RUN = 1'b1
  } tpn_run_e;

  // ---------------------------------------------------------------
  // enable pin and step enables
  // ---------------------------------------------------------------
  logic en_ok;
  logic pulse_tick;
  logic nr_tick;
  logic rxw_tick;

  tpn_sync3 u_en (
    .clk(clk),
    .reset(reset),
    .pin(en_pin),
    .level(en_ok)
  );

  tpn_step_tick #(
    .STEP_PS(tpn_pkg::PULSE_STEP_PS),
    .CLK_PS(tpn_pkg::CLK_PS)
  ) u_pulse_tick (
    .clk(clk),
    .reset(reset),
    .clear(tx_start && !tx_pulse),
    .tick(pulse_tick)
  );

  tpn_step_tick #(
    .STEP_PS(tpn_pkg::NORESP_STEP_PS),
    .CLK_PS(tpn_pkg::CLK_PS)
  ) u_nr_tick (
    .clk(clk),
    .reset(reset),
    .clear(tx_eof_end && !noresp_busy),
    .tick(nr_tick)
  );

  tpn_step_tick #(
    .STEP_PS(tpn_pkg::RXWAIT_STEP_PS),
    .CLK_PS(tpn_pkg::CLK_PS)
  ) u_rxw_tick (
    .clk(clk),
    .reset(reset),
    .clear(tx_eof_end),
    .tick(rxw_tick)
  );

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0] proto_sel;
  logic [7:0] pulse_ovr;
  logic [7:0] noresp;
  logic [7:0] rxwait;
  logic [tpn_pkg::IRQ_W-1:0] irq_mask;
  logic [7:0] next_proto_sel;
  logic [7:0] next_pulse_ovr;
  logic [7:0] next_noresp;
  logic [7:0] next_rxwait;
  logic [tpn_pkg::IRQ_W-1:0] next_irq_mask;
  tpn_pkg::tpn_proto_e proto_new;
  tpn_pkg::tpn_proto_e proto_cur;
  logic vicinity;

  always_comb begin
    proto_new = tpn_pkg::tpn_proto_e'(wdata[tpn_pkg::PROTO_LSB +: 2]);
    next_proto_sel = proto_sel;
    next_pulse_ovr = pulse_ovr;
    next_noresp = noresp;
    next_rxwait = rxwait;
    next_irq_mask = irq_mask;
    if (!en_ok) begin
      next_proto_sel = tpn_pkg::RST_PROTO;
      next_pulse_ovr = tpn_pkg::RST_PULSE; // R3
      next_noresp = tpn_pkg::RST_NORESP; // R8
      next_rxwait = tpn_pkg::RST_RXWAIT;
    end else if (wr) begin
      case (addr)
        tpn_pkg::ADDR_PROTO: begin
          next_proto_sel = wdata;
          next_pulse_ovr = 8'h00; // R3
          case (proto_new)
            tpn_pkg::TPN_VIC_LOW: begin
              next_noresp = tpn_pkg::NR_VIC_LOW; // R9
              next_rxwait = tpn_pkg::RXW_VIC;
            end
            tpn_pkg::TPN_VIC_HIGH: begin
              next_noresp = tpn_pkg::NR_VIC_HIGH; // R9
              next_rxwait = tpn_pkg::RXW_VIC;
            end
            default: begin
              next_noresp = tpn_pkg::NR_OTHER; // R9
              next_rxwait = tpn_pkg::RXW_OTHER;
            end
          endcase
        end
        tpn_pkg::ADDR_PULSE: next_pulse_ovr = wdata;
        tpn_pkg::ADDR_NORESP: next_noresp = wdata;
        tpn_pkg::ADDR_RXWAIT: next_rxwait = wdata;
        tpn_pkg::ADDR_IRQ_MASK: next_irq_mask = wdata[tpn_pkg::IRQ_W-1:0];
        default: next_proto_sel = proto_sel;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      proto_sel <= tpn_pkg::RST_PROTO;
      pulse_ovr <= tpn_pkg::RST_PULSE; // R3
      noresp <= tpn_pkg::RST_NORESP; // R8
      rxwait <= tpn_pkg::RST_RXWAIT;
      irq_mask <= tpn_pkg::RST_IRQ;
    end else begin
      proto_sel <= next_proto_sel;
      pulse_ovr <= next_pulse_ovr;
      noresp <= next_noresp;
      rxwait <= next_rxwait;
      irq_mask <= next_irq_mask;
    end
  end

  assign proto_cur = tpn_pkg::tpn_proto_e'(proto_sel[tpn_pkg::PROTO_LSB +: 2]);
  assign vicinity = (proto_cur == tpn_pkg::TPN_VIC_LOW) ||
                    (proto_cur == tpn_pkg::TPN_VIC_HIGH);

  // ---------------------------------------------------------------
  // transmit modulation pulse
  // ---------------------------------------------------------------
  tpn_run_e p_state;
  tpn_run_e next_p_state;
  logic [9:0] p_cnt;
  logic [9:0] next_p_cnt;
  logic [9:0] p_limit;
  logic p_inc;
  logic pulse_done;

  always_comb begin
    p_limit = tpn_pkg::PL_A106_CYC;
    if (pulse_ovr != 8'h00) begin
      p_limit = {2'b00, pulse_ovr}; // R2
    end else if (vicinity) begin
      p_limit = tpn_pkg::PL_VIC_CYC; // R1 R4
    end else begin
      case (proto_sel[tpn_pkg::RATE_LSB +: 2])
        2'h1: p_limit = tpn_pkg::PL_A212_CYC; // R4
        2'h2: p_limit = tpn_pkg::PL_A424_CYC; // R4
        2'h3: p_limit = tpn_pkg::PL_A848_CYC; // R4
        default: p_limit = tpn_pkg::PL_A106_CYC; // R4
      endcase
    end
    // override counts 73.7 ns steps, protocol length counts cycles
    p_inc = (pulse_ovr != 8'h00) ? pulse_tick : 1'b1; // R2
    next_p_state = p_state;
    next_p_cnt = p_cnt;
    pulse_done = 1'b0;
    case (p_state)
      TPN_IDLE: begin
        if (tx_start && en_ok) begin
          next_p_state = TPN_RUN;
          next_p_cnt = 10'h000;
        end
      end
      TPN_RUN: begin
        if (!en_ok) begin
          next_p_state = TPN_IDLE;
        end else if (p_inc) begin
          if (p_cnt + 10'h001 >= p_limit) begin
            next_p_state = TPN_IDLE;
            pulse_done = 1'b1;
          end else begin
            next_p_cnt = p_cnt + 10'h001;
          end
        end
      end
      default: next_p_state = TPN_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      p_state <= TPN_IDLE;
      p_cnt <= 10'h000;
    end else begin
      p_state <= next_p_state;
      p_cnt <= next_p_cnt;
    end
  end

  assign tx_pulse = (p_state == TPN_RUN);

  // ---------------------------------------------------------------
  // no-response timer and receive hold-off
  // ---------------------------------------------------------------
  tpn_run_e n_state;
  tpn_run_e next_n_state;
  logic [7:0] n_cnt;
  logic [7:0] next_n_cnt;
  logic [7:0] h_cnt;
  logic [7:0] next_h_cnt;
  logic nr_expire;

  always_comb begin
    next_n_state = n_state;
    next_n_cnt = n_cnt;
    nr_expire = 1'b0;
    case (n_state)
      TPN_IDLE: begin
        // zero wait is treated as timer off
        if (tx_eof_end && en_ok && noresp != 8'h00) begin
          next_n_state = TPN_RUN; // R5
          next_n_cnt = 8'h00;
        end
      end
      TPN_RUN: begin
        if (!en_ok || tag_resp_start) begin
          next_n_state = TPN_IDLE; // R12
        end else if (nr_tick) begin
          if (n_cnt + 8'h01 >= noresp) begin
            next_n_state = TPN_IDLE; // R7
            nr_expire = vicinity; // R6 R10
          end else begin
            next_n_cnt = n_cnt + 8'h01; // R7
          end
        end
      end
      default: next_n_state = TPN_IDLE;
    endcase
    next_h_cnt = h_cnt;
    if (!en_ok) begin
      next_h_cnt = 8'h00;
    end else if (tx_eof_end) begin
      next_h_cnt = rxwait; // R11
    end else if (rxw_tick && h_cnt != 8'h00) begin
      next_h_cnt = h_cnt - 8'h01; // R11
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      n_state <= TPN_IDLE;
      n_cnt <= 8'h00;
      h_cnt <= 8'h00;
    end else begin
      n_state <= next_n_state;
      n_cnt <= next_n_cnt;
      h_cnt <= next_h_cnt;
    end
  end

  assign noresp_busy = (n_state == TPN_RUN);
  assign rx_dec_hold = (h_cnt != 8'h00); // R11

  // ---------------------------------------------------------------
  // interrupt status and read port
  // ---------------------------------------------------------------
  logic [tpn_pkg::IRQ_W-1:0] irq_stat;
  logic [tpn_pkg::IRQ_W-1:0] next_irq_stat;
  logic [tpn_pkg::IRQ_W-1:0] irq_set;
  logic [tpn_pkg::IRQ_W-1:0] irq_clr;
  logic [7:0] next_rdata;

  always_comb begin
    irq_set = '0;
    irq_set[tpn_pkg::IRQ_NORESP_BIT] = nr_expire; // R6
    irq_set[tpn_pkg::IRQ_PULSE_BIT] = pulse_done;
    irq_clr = '0;
    if (wr && addr == tpn_pkg::ADDR_IRQ_STAT) begin
      irq_clr = wdata[tpn_pkg::IRQ_W-1:0];
    end
    // set wins so an event in the clearing cycle survives
    next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        tpn_pkg::ADDR_PROTO: next_rdata = proto_sel;
        tpn_pkg::ADDR_PULSE: next_rdata = pulse_ovr;
        tpn_pkg::ADDR_NORESP: next_rdata = noresp;
        tpn_pkg::ADDR_RXWAIT: next_rdata = rxwait;
        tpn_pkg::ADDR_IRQ_STAT: next_rdata = {6'h00, irq_stat};
        tpn_pkg::ADDR_IRQ_MASK: next_rdata = {6'h00, irq_mask};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat <= tpn_pkg::RST_IRQ;
      rdata <= 8'h00;
    end else begin
      irq_stat <= next_irq_stat;
      rdata <= next_rdata;
    end
  end

  assign irq = |(irq_stat & irq_mask); // R6
endmodule : tpn_timer
`default_nettype wire

// ==== core/tpn_fix_note.sv ====
`default_nettype none
`default_nettype wire

// ==== tb/tpn_timer_checker.sv ====
// Purpose: port checks for the pulse and no-response timer
// Assumes: one clock, synchronous active-high reset
// Notes: timer lengths checked as whole numbers of steps
`timescale 1ns/1ps
`default_nettype none
module tpn_timer_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic en_pin,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tx_start,
  input wire logic tx_pulse,
  input wire logic tx_eof_end,
  input wire logic tag_resp_start,
  input wire logic rx_dec_hold,
  input wire logic noresp_busy,
  input wire logic irq
);
  // ---------------------------------------------------------------
  // run-length counters
  // ---------------------------------------------------------------
  logic [19:0] busy_cnt;
  logic [19:0] next_busy_cnt;
  logic [19:0] hold_cnt;
  logic [19:0] next_hold_cnt;
  logic [19:0] pulse_cnt;
  logic [19:0] next_pulse_cnt;
  always_comb begin
    next_busy_cnt = noresp_busy ? busy_cnt + 20'h1 : 20'h0;
    next_hold_cnt = rx_dec_hold ? hold_cnt + 20'h1 : 20'h0;
    next_pulse_cnt = tx_pulse ? pulse_cnt + 20'h1 : 20'h0;
  end
  always_ff @(posedge clk) begin
    busy_cnt <= reset ? 20'h0 : next_busy_cnt;
    hold_cnt <= reset ? 20'h0 : next_hold_cnt;
    pulse_cnt <= reset ? 20'h0 : next_pulse_cnt;
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  pulse_cause_a: assert property (
    $rose(tx_pulse) |-> $past(tx_start)) else $error("pulse without start");
  pulse_min_a: assert property (
    $rose(tx_pulse) |-> tx_pulse[*8]) else $error("pulse below one step");
  pulse_max_a: assert property (
    pulse_cnt <= 20'h758) else $error("pulse above 255 steps");
  busy_cause_a: assert property (
    $rose(noresp_busy) |-> $past(tx_eof_end)) else $error("timer not on eof");
  resp_stop_a: assert property (
    noresp_busy && tag_resp_start |=> !noresp_busy)
    else $error("response did not stop timer");
  // en low aborts the timer, so only full runs are measured
  busy_len_a: assert property (
    $fell(noresp_busy) && en_pin && !$past(tag_resp_start)
    |-> busy_cnt % 20'hEC0 == 20'h0) else $error("wait not whole steps");
  hold_cause_a: assert property (
    $rose(rx_dec_hold) |-> $past(tx_eof_end)) else $error("hold not on eof");
  hold_len_a: assert property (
    $fell(rx_dec_hold) && en_pin |-> hold_cnt % 20'h3B0 == 20'h0)
    else $error("hold not whole steps");
endmodule : tpn_timer_checker
bind tpn_timer tpn_timer_checker u_tpn_timer_checker (
  .clk(clk), .reset(reset), .en_pin(en_pin), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .tx_start(tx_start),
  .tx_pulse(tx_pulse), .tx_eof_end(tx_eof_end),
  .tag_resp_start(tag_resp_start), .rx_dec_hold(rx_dec_hold),
  .noresp_busy(noresp_busy), .irq(irq));
`default_nettype wire

// ==== tb/tpn_host_model.sv ====
// Purpose: host controller model driving the register port
// Assumes: read data one cycle after the read strobe
// Notes: one idle edge between accesses keeps strobes single
`timescale 1ns/1ps
`default_nettype none
module tpn_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var logic [7:0] addr,
  output var logic [7:0] wdata,
  output var logic wr,
  output var logic rd
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
endmodule : tpn_host_model
`default_nettype wire

// ==== tb/test_tx_pulse_and_no_response_timer.sv ====
// Purpose: register, pulse and no-response tests of the timer
// Assumes: en_pin high except in the enable test
// Notes: long waits shortened by writing small step counts
`timescale 1ns/1ps
`default_nettype none
module test_tx_pulse_and_no_response_timer;
  logic clk, reset, en_pin, wr, rd, tx_start, tx_pulse, tx_eof_end;
  logic tag_resp_start, rx_dec_hold, noresp_busy, irq;
  logic [7:0] addr, wdata, rdata;
  logic [19:0] nb, nh, np;
  int mismatches, n_checks, cyc;
  logic [7:0] nr_tab [4] = '{8'h30, 8'h14, 8'h0E, 8'h0E};
  logic [7:0] pr_tab [9] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h0A, 8'h0E,
    8'h03, 8'h02, 8'h02};
  int ov_tab [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 255};
  int ns_tab [9] = '{9440, 9440, 2360, 1400, 737, 442, 2360, 0, 0};
  tpn_timer u_tpn_timer (.clk(clk), .reset(reset), .en_pin(en_pin),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tx_start(tx_start), .tx_pulse(tx_pulse), .tx_eof_end(tx_eof_end),
    .tag_resp_start(tag_resp_start), .rx_dec_hold(rx_dec_hold),
    .noresp_busy(noresp_busy), .irq(irq));
  tpn_host_model u_tpn_host_model (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_tpn_host_model.rd_reg(a, d);
    chk({12'h0, d}, {12'h0, exp});
  endtask : rchk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    u_tpn_host_model.wr_reg(a, d);
  endtask : wreg
  task automatic eof_pulse();
    @(posedge clk);
    tx_eof_end <= 1'b1;
    @(posedge clk);
    tx_eof_end <= 1'b0;
    #1;
  endtask : eof_pulse
  // counts busy and hold cycles until both end; guard stops a hang
  task automatic run_eof();
    nb = 20'h0;
    nh = 20'h0;
    eof_pulse();
    while ((noresp_busy === 1'b1 || rx_dec_hold === 1'b1) && nb < 20'hFFFF)
    begin
      nb = nb + {19'h0, noresp_busy};
      nh = nh + {19'h0, rx_dec_hold};
      @(posedge clk);
      #1;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : run_eof
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      close_out();
    end
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    en_pin = 1'b1;
    tx_start = 1'b0;
    tx_eof_end = 1'b0;
    tag_resp_start = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    rchk(tpn_pkg::ADDR_PULSE, 8'h00);
    rchk(tpn_pkg::ADDR_NORESP, 8'h0E);
    rchk(8'h20, 8'h00);
    $display("reset values done");
    for (int p = 0; p < 4; p++) begin
      wreg(tpn_pkg::ADDR_PULSE, 8'h55);
      wreg(tpn_pkg::ADDR_NORESP, 8'h99);
      wreg(tpn_pkg::ADDR_PROTO, 8'(p));
      rchk(tpn_pkg::ADDR_PULSE, 8'h00);
      rchk(tpn_pkg::ADDR_NORESP, nr_tab[p]);
    end
    wreg(tpn_pkg::ADDR_PULSE, 8'h33);
    rchk(tpn_pkg::ADDR_PULSE, 8'h33);
    en_pin <= 1'b0;
    repeat (10) @(posedge clk);
    en_pin <= 1'b1;
    repeat (8) @(posedge clk);
    rchk(tpn_pkg::ADDR_PULSE, 8'h00);
    rchk(tpn_pkg::ADDR_NORESP, 8'h0E);
    $display("presets done");
    for (int i = 0; i < 9; i++) begin
      wreg(tpn_pkg::ADDR_PROTO, pr_tab[i]);
      wreg(tpn_pkg::ADDR_PULSE, 8'(ov_tab[i]));
      @(posedge clk);
      tx_start <= 1'b1;
      @(posedge clk);
      tx_start <= 1'b0;
      #1;
      np = 20'h0;
      while (tx_pulse === 1'b1 && np < 20'hFA0) begin
        np = np + 20'h1;
        @(posedge clk);
        #1;
      end
      if (ov_tab[i] == 0) begin
        chk(np, 20'((ns_tab[i] + 9) / 10));
      end else begin
        chk(np, 20'((ov_tab[i] * 737 + 99) / 100));
      end
    end
    rchk(tpn_pkg::ADDR_IRQ_STAT, 8'h02);
    wreg(tpn_pkg::ADDR_IRQ_STAT, 8'h03);
    $display("pulse lengths done");
    wreg(tpn_pkg::ADDR_PROTO, 8'h00);
    wreg(tpn_pkg::ADDR_NORESP, 8'h02);
    wreg(tpn_pkg::ADDR_RXWAIT, 8'h02);
    wreg(tpn_pkg::ADDR_IRQ_MASK, 8'h01);
    run_eof();
    chk(nb, 20'(2 * 3776));
    chk(nh, 20'(2 * 944));
    chk({19'h0, irq}, 20'h1);
    rchk(tpn_pkg::ADDR_IRQ_STAT, 8'h01);
    wreg(tpn_pkg::ADDR_IRQ_STAT, 8'h01);
    wreg(tpn_pkg::ADDR_IRQ_MASK, 8'h00);
    wreg(tpn_pkg::ADDR_NORESP, 8'h01);
    run_eof();
    chk({19'h0, irq}, 20'h0);
    rchk(tpn_pkg::ADDR_IRQ_STAT, 8'h01);
    wreg(tpn_pkg::ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk);
    chk({19'h0, irq}, 20'h1);
    wreg(tpn_pkg::ADDR_IRQ_STAT, 8'h01);
    repeat (2) @(posedge clk);
    chk({19'h0, irq}, 20'h0);
    $display("no-response expiry done");
    wreg(tpn_pkg::ADDR_PROTO, 8'h02);
    wreg(tpn_pkg::ADDR_NORESP, 8'h01);
    wreg(tpn_pkg::ADDR_RXWAIT, 8'h00);
    run_eof();
    chk(nb, 20'(3776));
    rchk(tpn_pkg::ADDR_IRQ_STAT, 8'h00);
    chk({19'h0, irq}, 20'h0);
    wreg(tpn_pkg::ADDR_PROTO, 8'h00);
    wreg(tpn_pkg::ADDR_NORESP, 8'h01);
    eof_pulse();
    repeat (100) @(posedge clk);
    tag_resp_start <= 1'b1;
    @(posedge clk);
    tag_resp_start <= 1'b0;
    @(posedge clk);
    #1;
    chk({19'h0, noresp_busy}, 20'h0);
    repeat (4000) @(posedge clk);
    rchk(tpn_pkg::ADDR_IRQ_STAT, 8'h00);
    $display("protocol gate and response stop done");
    close_out();
  end
endmodule : test_tx_pulse_and_no_response_timer
`default_nettype wire
